/* File: shared/dlc_pkg.sv */
// package for the dram latency and burst configuration block
package dlc_pkg;

	// ------------------------------------------------------------------
	// register addresses and reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_FEATURE_ONE  = 8'h01;
	localparam logic [7:0] ADDR_FEATURE_TWO  = 8'h02;
	localparam logic [7:0] FEATURE_ONE_RESET = 8'h00;
	localparam logic [7:0] FEATURE_TWO_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ     = 8'h00;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int BURST_LSB     = 0;
	localparam int WR_PRE_BIT    = 2;
	localparam int RD_PRE_BIT    = 3;
	localparam int WR_REC_LSB    = 4;
	localparam int RD_POST_BIT   = 7;
	localparam int RD_LAT_LSB    = 0;
	localparam int WR_LAT_LSB    = 3;
	localparam int WR_LAT_SET    = 6;
	localparam int WR_LEVEL_BIT  = 7;

	// ------------------------------------------------------------------
	// burst codes and counts
	// ------------------------------------------------------------------
	localparam logic [1:0] BURST_FIXED16 = 2'h0;
	localparam logic [1:0] BURST_FIXED32 = 2'h1;
	localparam logic [1:0] BURST_OTF     = 2'h2;
	localparam logic [4:0] LAST_BEAT16   = 5'h0f;
	localparam logic [4:0] LAST_BEAT32   = 5'h1f;
	localparam logic [5:0] BL32_RTP_ADD  = 6'h08;

	// ------------------------------------------------------------------
	// latency tables, index is the field code
	// ------------------------------------------------------------------
	localparam logic [7:0][5:0] WR_REC_TABLE = {6'h28, 6'h22, 6'h1e, 6'h18,
		6'h14, 6'h10, 6'h0a, 6'h06};
	localparam logic [7:0][5:0] RL_PLAIN_TABLE = {6'h24, 6'h20, 6'h1c,
		6'h18, 6'h14, 6'h0e, 6'h0a, 6'h06};
	localparam logic [7:0][5:0] RL_INV_TABLE = {6'h28, 6'h24, 6'h20, 6'h1c,
		6'h16, 6'h10, 6'h0c, 6'h06};
	localparam logic [7:0][5:0] RTP_TABLE = {6'h10, 6'h0e, 6'h0c, 6'h0a,
		6'h08, 6'h08, 6'h08, 6'h08};
	// code 7 is unlisted; it repeats the largest value of its set
	localparam logic [7:0][5:0] WL_A_TABLE = {6'h10, 6'h10, 6'h0e, 6'h0c,
		6'h0a, 6'h08, 6'h06, 6'h04};
	localparam logic [7:0][5:0] WL_B_TABLE = {6'h22, 6'h22, 6'h1a, 6'h16,
		6'h12, 6'h0c, 6'h08, 6'h04};

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [1:0] burst_length;
		logic       read_preamble_toggle;
		logic       write_preamble_two;
		logic [5:0] write_recovery_count;
		logic       read_postamble_len;
		logic [5:0] read_latency;
		logic [5:0] write_latency;
		logic [5:0] read_to_precharge_count;
		logic       write_leveling;
	} dlc_cfg_s;

	typedef enum logic [1:0] {
		BST_IDLE,
		BST_LATENCY,
		BST_BURST,
		BST_PRECHARGE
	} dlc_burst_state_e;

endpackage

/* File: verilog/dlc_sync.sv */
// two flip-flop synchroniser for levels and toggles
`timescale 1ns/1ps
`default_nettype none

module dlc_sync #(
	parameter int           W         = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	// clock and reset of the receiving domain
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	// crossing signal
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} dlc_sync_s;

	dlc_sync_s state;
	dlc_sync_s next_state;

	if (W < 1) begin : g_bad_width
		$error("dlc_sync width must be positive");
	end

	// meta is read by the second stage only
	always_comb begin
		next_state.meta = async_i;
		next_state.sync = state.meta;
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			state.meta <= RESET_VAL;
			state.sync <= RESET_VAL;
		end else begin
			state <= next_state;
		end
	end

	assign sync_o = state.sync;

endmodule

`default_nettype wire

/* File: verilog/dlc_config_top.sv */
// mode registers for burst, latency and recovery, with burst sequencer
// Operation
// - burst code: 16, 32, or per-command choice
// - read preamble static/toggle; write preamble bit set
// - write recovery code maps 6 to 40 clocks
// - read postamble half or one-and-half clock
// - two copies; reads return write-selected copy
// - operate from active copy; leveling from last feature-two write to either copy
// - read latency code, two tables by inversion
// - write latency set A or B
// - read precharge delay, plus 8 for 32
// - lowest two column bits taken as zero
// - beats step column offset by one
// - write leveling blocks commands until cleared
`timescale 1ns/1ps
`default_nettype none

module dlc_config_top #(
	parameter int COL_W = 10
) (
	// clocks and reset
	input  wire logic                 clk_sys_i,
	input  wire logic                 rstn_i,
	input  wire logic                 clk_link_i,
	// mode register access, link clock
	input  wire logic                 mrw_valid_i,
	input  wire logic [7:0]           mrw_addr_i,
	input  wire logic [7:0]           mrw_data_i,
	input  wire logic                 mrr_valid_i,
	input  wire logic [7:0]           mrr_addr_i,
	output logic                      mrr_valid_o,
	output logic      [7:0]           mrr_data_o,
	// set point and inversion selects, link clock
	input  wire logic                 write_set_point_select_i,
	input  wire logic                 operating_set_point_select_i,
	input  wire logic                 read_inversion_enable_i,
	// column commands, link clock
	input  wire logic                 cmd_valid_i,
	input  wire logic                 cmd_write_i,
	input  wire logic                 cmd_burst_sel_i,
	input  wire logic                 auto_precharge_i,
	input  wire logic [COL_W-1:2]     cmd_col_i,
	output logic                      cmd_ready_o,
	output logic                      beat_valid_o,
	output logic                      beat_write_o,
	output logic      [COL_W-1:0]     beat_col_o,
	output logic                      precharge_start_o,
	output logic                      write_leveling_o,
	// decoded active configuration, system clock
	output dlc_pkg::dlc_cfg_s         cfg_o,
	output logic                      cfg_update_o
);

	if (COL_W < 5) begin : g_bad_col
		$error("column width too small for a 32-beat burst");
	end

	// ------------------------------------------------------------------
	// decode of one register pair
	// ------------------------------------------------------------------
	function automatic dlc_pkg::dlc_cfg_s dlc_decode(input logic [7:0] f1,
		input logic [7:0] f2, input logic lev, input logic inv);
		dlc_pkg::dlc_cfg_s c;
		logic [2:0]        rl_code;
		logic [2:0]        wl_code;
		rl_code = f2[dlc_pkg::RD_LAT_LSB +: 3];
		wl_code = f2[dlc_pkg::WR_LAT_LSB +: 3];
		c.burst_length = f1[dlc_pkg::BURST_LSB +: 2];
		c.write_preamble_two = f1[dlc_pkg::WR_PRE_BIT];
		c.read_preamble_toggle = f1[dlc_pkg::RD_PRE_BIT];
		c.write_recovery_count =
			dlc_pkg::WR_REC_TABLE[f1[dlc_pkg::WR_REC_LSB +: 3]];
		c.read_postamble_len = f1[dlc_pkg::RD_POST_BIT];
		c.read_latency = inv ? dlc_pkg::RL_INV_TABLE[rl_code]
			: dlc_pkg::RL_PLAIN_TABLE[rl_code];
		c.read_to_precharge_count = dlc_pkg::RTP_TABLE[rl_code];
		c.write_latency = f2[dlc_pkg::WR_LAT_SET]
			? dlc_pkg::WL_B_TABLE[wl_code]
			: dlc_pkg::WL_A_TABLE[wl_code];
		c.write_leveling = lev;
		return c;
	endfunction

	localparam dlc_pkg::dlc_cfg_s CFG_RESET = dlc_decode(
		dlc_pkg::FEATURE_ONE_RESET, dlc_pkg::FEATURE_TWO_RESET,
		1'b0, 1'b0);

	// ------------------------------------------------------------------
	// state of both domains
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [1:0][7:0]           feat_one;
		logic [1:0][7:0]           feat_two;
		logic                      wr_lev;
		dlc_pkg::dlc_burst_state_e state;
		logic [5:0]                count;
		logic [5:0]                since;
		logic [COL_W-1:0]          start_col;
		logic [4:0]                offset;
		logic                      burst32;
		logic                      is_write;
		logic                      auto_pre;
		logic                      cmd_ready;
		logic                      beat_valid;
		logic [COL_W-1:0]          beat_col;
		logic                      precharge;
		logic                      mrr_valid;
		logic [7:0]                mrr_data;
		dlc_pkg::dlc_cfg_s         snap;
		logic                      upd;
		logic                      pending;
	} dlc_link_s;

	typedef struct packed {
		dlc_pkg::dlc_cfg_s cfg;
		logic              ack;
		logic              update;
	} dlc_sys_s;

	dlc_link_s         ln;
	dlc_link_s         next_ln;
	dlc_sys_s          sy;
	dlc_sys_s          next_sy;
	dlc_pkg::dlc_cfg_s act;
	logic              link_rstn;
	logic              upd_sync;
	logic              ack_sync;
	logic              accept;
	logic [5:0]        lat;
	logic [5:0]        pre_delay;

	// ------------------------------------------------------------------
	// crossings
	// ------------------------------------------------------------------
	dlc_sync #(.W(1), .RESET_VAL(1'b0)) u_link_reset (
		.clk_i   (clk_link_i),
		.rstn_i  (1'b1),
		.async_i (rstn_i),
		.sync_o  (link_rstn)
	);

	dlc_sync #(.W(1), .RESET_VAL(1'b0)) u_upd_sync (
		.clk_i   (clk_sys_i),
		.rstn_i  (rstn_i),
		.async_i (ln.upd),
		.sync_o  (upd_sync)
	);

	dlc_sync #(.W(1), .RESET_VAL(1'b0)) u_ack_sync (
		.clk_i   (clk_link_i),
		.rstn_i  (link_rstn),
		.async_i (sy.ack),
		.sync_o  (ack_sync)
	);

	// ------------------------------------------------------------------
	// link domain
	// ------------------------------------------------------------------
	// the inactive copy is never read for operation
	assign act = dlc_decode(ln.feat_one[operating_set_point_select_i],
		ln.feat_two[operating_set_point_select_i], ln.wr_lev,
		read_inversion_enable_i);
	assign accept = cmd_valid_i && ln.cmd_ready;
	assign lat = cmd_write_i ? act.write_latency : act.read_latency;
	assign pre_delay = ln.is_write ? act.write_recovery_count
		: act.read_to_precharge_count
		+ (ln.burst32 ? dlc_pkg::BL32_RTP_ADD : 6'h00);

	always_comb begin
		next_ln = ln;
		next_ln.beat_valid = 1'b0;
		next_ln.precharge = 1'b0;
		next_ln.mrr_valid = 1'b0;
		next_ln.since = (ln.since == 6'h3f) ? ln.since : ln.since + 6'h01;
		// only writes to the leveling register pass while leveling
		if (mrw_valid_i) begin
			if (mrw_addr_i == dlc_pkg::ADDR_FEATURE_ONE && !ln.wr_lev)
				next_ln.feat_one[write_set_point_select_i] = mrw_data_i;
			if (mrw_addr_i == dlc_pkg::ADDR_FEATURE_TWO) begin
				next_ln.feat_two[write_set_point_select_i] = mrw_data_i;
				next_ln.wr_lev = mrw_data_i[dlc_pkg::WR_LEVEL_BIT];
			end
		end
		if (mrr_valid_i && !ln.wr_lev) begin
			next_ln.mrr_valid = 1'b1;
			if (mrr_addr_i == dlc_pkg::ADDR_FEATURE_ONE)
				next_ln.mrr_data = ln.feat_one[write_set_point_select_i];
			else if (mrr_addr_i == dlc_pkg::ADDR_FEATURE_TWO)
				next_ln.mrr_data = ln.feat_two[write_set_point_select_i];
			else
				next_ln.mrr_data = dlc_pkg::UNMAPPED_READ;
		end
		unique case (ln.state)
			dlc_pkg::BST_IDLE: begin
				if (accept) begin
					next_ln.burst32 = (act.burst_length == dlc_pkg::BURST_FIXED32)
						|| (act.burst_length == dlc_pkg::BURST_OTF
						&& cmd_burst_sel_i);
					next_ln.start_col = {cmd_col_i, 2'b00};
					next_ln.is_write = cmd_write_i;
					next_ln.auto_pre = auto_precharge_i;
					next_ln.count = lat - 6'h02;
					next_ln.since = 6'h00;
					next_ln.state = dlc_pkg::BST_LATENCY;
				end
			end
			dlc_pkg::BST_LATENCY: begin
				next_ln.count = ln.count - 6'h01;
				if (ln.count == 6'h00) begin
					next_ln.offset = 5'h00;
					next_ln.state = dlc_pkg::BST_BURST;
				end
			end
			dlc_pkg::BST_BURST: begin
				next_ln.beat_valid = 1'b1;
				// offset steps within the aligned burst window
				if (ln.burst32)
					next_ln.beat_col = {ln.start_col[COL_W-1:5],
						ln.start_col[4:0] + ln.offset};
				else
					next_ln.beat_col = {ln.start_col[COL_W-1:4],
						ln.start_col[3:0] + ln.offset[3:0]};
				next_ln.offset = ln.offset + 5'h01;
				if (ln.offset == (ln.burst32 ? dlc_pkg::LAST_BEAT32
					: dlc_pkg::LAST_BEAT16)) begin
					next_ln.since = 6'h00;
					next_ln.count = pre_delay - 6'h01;
					next_ln.state = ln.auto_pre ? dlc_pkg::BST_PRECHARGE
						: dlc_pkg::BST_IDLE;
				end
			end
			dlc_pkg::BST_PRECHARGE: begin
				next_ln.count = ln.count - 6'h01;
				if (ln.count == 6'h00) begin
					next_ln.precharge = 1'b1;
					next_ln.state = dlc_pkg::BST_IDLE;
				end
			end
		endcase
		next_ln.cmd_ready = (next_ln.state == dlc_pkg::BST_IDLE)
			&& !next_ln.wr_lev;
		// snapshot stays still while the system side has not answered
		if (ln.pending && ack_sync == ln.upd)
			next_ln.pending = 1'b0;
		else if (!ln.pending && act != ln.snap) begin
			next_ln.snap = act;
			next_ln.upd = !ln.upd;
			next_ln.pending = 1'b1;
		end
	end

	always_ff @(posedge clk_link_i) begin
		if (!link_rstn) begin
			ln <= '0;
			ln.feat_one <= {2{dlc_pkg::FEATURE_ONE_RESET}};
			ln.feat_two <= {2{dlc_pkg::FEATURE_TWO_RESET}};
			ln.snap <= CFG_RESET;
		end else begin
			ln <= next_ln;
		end
	end

	// ------------------------------------------------------------------
	// system domain
	// ------------------------------------------------------------------
	always_comb begin
		next_sy = sy;
		next_sy.update = 1'b0;
		if (upd_sync != sy.ack) begin
			next_sy.cfg = ln.snap;
			next_sy.ack = upd_sync;
			next_sy.update = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			sy.cfg <= CFG_RESET;
			sy.ack <= 1'b0;
			sy.update <= 1'b0;
		end else begin
			sy <= next_sy;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign mrr_valid_o = ln.mrr_valid;
	assign mrr_data_o = ln.mrr_data;
	assign cmd_ready_o = ln.cmd_ready;
	assign beat_valid_o = ln.beat_valid;
	assign beat_write_o = ln.is_write;
	assign beat_col_o = ln.beat_col;
	assign precharge_start_o = ln.precharge;
	assign write_leveling_o = ln.wr_lev;
	assign cfg_o = sy.cfg;
	assign cfg_update_o = sy.update;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	a_write_copy_kept: assert property (@(posedge clk_link_i)
		disable iff (!link_rstn)
		mrw_valid_i && mrw_addr_i == dlc_pkg::ADDR_FEATURE_TWO
		|=> ln.feat_two[$past(write_set_point_select_i)]
		== $past(mrw_data_i)) else $error("feature two copy not written");
	a_inactive_copy_stable: assert property (@(posedge clk_link_i)
		disable iff (!link_rstn)
		mrw_valid_i && mrw_addr_i == dlc_pkg::ADDR_FEATURE_ONE
		|=> ln.feat_one[!$past(write_set_point_select_i)]
		== $past(ln.feat_one[!write_set_point_select_i]))
		else $error("other set point disturbed");
	a_read_returns_copy: assert property (@(posedge clk_link_i)
		disable iff (!link_rstn)
		mrr_valid_i && !ln.wr_lev
		&& mrr_addr_i == dlc_pkg::ADDR_FEATURE_ONE && !mrw_valid_i
		|=> mrr_valid_o
		&& mrr_data_o == ln.feat_one[$past(write_set_point_select_i)])
		else $error("mode read returned wrong copy");
	a_beat_step_one: assert property (@(posedge clk_link_i)
		disable iff (!link_rstn)
		beat_valid_o && $past(beat_valid_o) && ln.offset != 5'h01
		|-> beat_col_o[3:0] == $past(beat_col_o[3:0]) + 4'h1)
		else $error("burst column did not step by one");
	a_start_low_zero: assert property (@(posedge clk_link_i)
		disable iff (!link_rstn)
		$rose(beat_valid_o) |-> beat_col_o[1:0] == 2'b00)
		else $error("burst start column not four-aligned");
	a_burst_length: assert property (@(posedge clk_link_i)
		disable iff (!link_rstn)
		$fell(beat_valid_o) |-> $past(ln.offset)
		== (ln.burst32 ? 5'h00 : 5'h10)) else $error("burst length wrong");
	a_latency_wait: assert property (@(posedge clk_link_i)
		disable iff (!link_rstn)
		$rose(beat_valid_o) |-> ln.since == (beat_write_o
		? act.write_latency : act.read_latency))
		else $error("latency before first beat wrong");
	a_precharge_delay: assert property (@(posedge clk_link_i)
		disable iff (!link_rstn)
		precharge_start_o |-> ln.since == (beat_write_o
		? act.write_recovery_count
		: act.read_to_precharge_count
		+ (ln.burst32 ? dlc_pkg::BL32_RTP_ADD : 6'h00)))
		else $error("auto precharge delay wrong");
	// the write that clears leveling reopens the command path at once
	a_level_blocks: assert property (@(posedge clk_link_i)
		disable iff (!link_rstn)
		write_leveling_o && ln.state == dlc_pkg::BST_IDLE && !(mrw_valid_i
		&& mrw_addr_i == dlc_pkg::ADDR_FEATURE_TWO
		&& !mrw_data_i[dlc_pkg::WR_LEVEL_BIT])
		|=> ln.state == dlc_pkg::BST_IDLE && !cmd_ready_o)
		else $error("command taken during write leveling");
	a_cfg_follows: assert property (@(posedge clk_sys_i)
		disable iff (!rstn_i)
		cfg_update_o |-> cfg_o.read_postamble_len
		== $past(ln.snap.read_postamble_len))
		else $error("system config not taken from snapshot");

	c_write_ap32: cover property (@(posedge clk_link_i)
		disable iff (!link_rstn)
		precharge_start_o && beat_write_o && ln.burst32);
	c_read_ap16: cover property (@(posedge clk_link_i)
		disable iff (!link_rstn)
		precharge_start_o && !beat_write_o && !ln.burst32);
	c_level_entry: cover property (@(posedge clk_link_i)
		disable iff (!link_rstn) $rose(write_leveling_o));
	c_cfg_update: cover property (@(posedge clk_sys_i)
		disable iff (!rstn_i) cfg_update_o);

endmodule

`default_nettype wire

/* File: verification/dlc_ctrl_model.sv */
// controller model driving the mode register and column command bus
`timescale 1ns/1ps
`default_nettype none

module dlc_ctrl_model (
	// link clock and answers
	input  wire logic       clk_i,
	input  wire logic       ready_i,
	input  wire logic       lev_i,
	input  wire logic       rd_valid_i,
	input  wire logic [7:0] rd_data_i,
	// requests
	output logic            wr_o,
	output logic            rd_o,
	output logic      [7:0] addr_o,
	output logic      [7:0] data_o,
	output logic            cmd_o,
	output logic            cmd_wr_o,
	output logic            sel_o,
	output logic            ap_o,
	output logic      [7:0] col_o
);
	// ------------------------------------------------------------------
	// bus tasks
	// ------------------------------------------------------------------
	initial begin
		{wr_o, rd_o, addr_o, data_o} = '0;
		{cmd_o, cmd_wr_o, sel_o, ap_o, col_o} = '0;
	end

	// released lines show the inverse, not a stale copy
	task automatic mrw(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_o <= 1'b1;
		addr_o <= a;
		data_o <= d;
		@(posedge clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		data_o <= ~d;
	endtask

	task automatic mrr(input logic [7:0] a, output logic [7:0] d,
		output logic ok);
		ok = 1'b0;
		d = 8'h00;
		@(posedge clk_i);
		rd_o <= 1'b1;
		addr_o <= a;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		repeat (3) begin
			@(negedge clk_i);
			if (rd_valid_i && !ok) begin
				ok = 1'b1;
				d = rd_data_i;
			end
		end
	endtask

	task automatic cmd(input logic w, input logic s, input logic p,
		input logic [7:0] c);
		int n;
		n = 0;
		// no command while leveling is on
		while (lev_i && n < 100) begin
			@(negedge clk_i);
			n++;
		end
		@(posedge clk_i);
		cmd_o <= 1'b1;
		cmd_wr_o <= w;
		sel_o <= s;
		ap_o <= p;
		// column bits 1:0 never sent; writes clear bits 3:2
		col_o <= w ? {c[7:2], 2'b00} : c;
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (!ready_i && n < 200);
		@(posedge clk_i);
		cmd_o <= 1'b0;
		cmd_wr_o <= ~w;
		col_o <= ~c;
	endtask
endmodule

`default_nettype wire

/* File: verification/dlc_config_top_tb_top.sv */
// testbench for the mode register and burst configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin \
	num_errors++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end

module dlc_config_top_tb_top;
	// ------------------------------------------------------------------
	// clocks, wiring, monitor
	// ------------------------------------------------------------------
	logic clk_sys_i = 0, clk_link_i = 0, rstn_i = 0;
	logic wsel = 0, osel = 0, inv = 0, kw = 0, ok;
	logic mw, mr, cv, cw, cs, ap, ready, rv, bv, bw, pcs, lev, upd;
	logic [7:0] addr, data, col, rdat, rd;
	logic [9:0] bcol, base, m;
	dlc_pkg::dlc_cfg_s cfg;
	int num_errors = 0, n_checks = 0, n;
	int lcnt = 0, acc, fb, lb, pc, nb, cerr;
	int rlp[8] = '{6, 10, 14, 20, 24, 28, 32, 36};
	int rli[8] = '{6, 12, 16, 22, 28, 32, 36, 40};
	int wla[8] = '{4, 6, 8, 10, 12, 14, 16, 16};
	int wlb[8] = '{4, 8, 12, 18, 22, 26, 34, 34};
	int wrr[8] = '{6, 10, 16, 20, 24, 30, 34, 40};
	int rtp[8] = '{8, 8, 8, 8, 10, 12, 14, 16};

	always #25 clk_sys_i = ~clk_sys_i;
	always #15 clk_link_i = ~clk_link_i;

	dlc_config_top dut (
		.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .clk_link_i(clk_link_i),
		.mrw_valid_i(mw), .mrw_addr_i(addr), .mrw_data_i(data),
		.mrr_valid_i(mr), .mrr_addr_i(addr), .mrr_valid_o(rv),
		.mrr_data_o(rdat), .write_set_point_select_i(wsel),
		.operating_set_point_select_i(osel), .read_inversion_enable_i(inv),
		.cmd_valid_i(cv), .cmd_write_i(cw), .cmd_burst_sel_i(cs),
		.auto_precharge_i(ap), .cmd_col_i(col), .cmd_ready_o(ready),
		.beat_valid_o(bv), .beat_write_o(bw), .beat_col_o(bcol),
		.precharge_start_o(pcs), .write_leveling_o(lev), .cfg_o(cfg),
		.cfg_update_o(upd));

	dlc_ctrl_model ctl (
		.clk_i(clk_link_i), .ready_i(ready), .lev_i(lev), .rd_valid_i(rv),
		.rd_data_i(rdat), .wr_o(mw), .rd_o(mr), .addr_o(addr),
		.data_o(data), .cmd_o(cv), .cmd_wr_o(cw), .sel_o(cs), .ap_o(ap),
		.col_o(col));

	always @(posedge clk_link_i) lcnt <= lcnt + 1;

	// registered outputs sampled mid-cycle to stay clear of edge races
	always @(negedge clk_link_i) begin
		if (cv && ready) acc = lcnt + 1;
		if (bv) begin
			if (nb == 0) fb = lcnt;
			if (bcol !== ((base & ~m) | ((base + 10'(nb)) & m))) cerr++;
			if (bw !== kw) cerr++;
			nb++;
			lb = lcnt;
		end
		if (pcs) pc = lcnt;
	end

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic wupd();
		int k;
		k = 0;
		while (!upd && k < 60) begin
			@(negedge clk_sys_i);
			k++;
		end
		`CHK("update", 1'b1, upd)
		@(negedge clk_sys_i);
	endtask

	task automatic run(input logic w, input logic s, input logic p,
		input logic [7:0] c, input int l, input int nn, input int d);
		int k;
		nb = 0;
		pc = 0;
		cerr = 0;
		kw = w;
		base = {w ? {c[7:2], 2'b00} : c, 2'b00};
		m = 10'(nn - 1);
		ctl.cmd(w, s, p, c);
		k = 0;
		while ((nb < nn || (p && pc == 0)) && k < 200) begin
			@(negedge clk_link_i);
			k++;
		end
		repeat (3) @(negedge clk_link_i);
		`CHK("first beat", l, fb - acc)
		`CHK("beats", nn, nb)
		`CHK("columns", 0, cerr)
		`CHK("precharge", d, p ? pc - lb : pc)
	endtask

	initial begin
		#1000000;
		num_errors++;
		complete_run();
	end

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		repeat (4) @(posedge clk_link_i);
		`CHK("burst", 2'h0, cfg.burst_length)
		`CHK("recovery", 6'h06, cfg.write_recovery_count)
		`CHK("read lat", 6'h06, cfg.read_latency)
		`CHK("write lat", 6'h04, cfg.write_latency)
		for (int k = 0; k < 4; k++) begin
			@(posedge clk_link_i) wsel <= k[1];
			ctl.mrr(k[0] ? 8'h02 : 8'h01, rd, ok);
			`CHK("reset read", 9'h100, {ok, rd})
		end
		ctl.mrr(8'h03, rd, ok);
		`CHK("unmapped", 9'h100, {ok, rd})
		@(posedge clk_link_i) wsel <= 1'b0;
		for (int b = 0; b < 2; b++) begin
			@(posedge clk_link_i) inv <= b[0];
			for (int i = 7; i >= 0; i--) begin
				ctl.mrw(8'h02, {1'b0, b[0], i[2:0], i[2:0]});
				wupd();
				`CHK("read lat", b ? rli[i] : rlp[i], cfg.read_latency)
				`CHK("write lat", b ? wlb[i] : wla[i], cfg.write_latency)
				`CHK("rtp", rtp[i], cfg.read_to_precharge_count)
				ctl.mrw(8'h01, {i[0], i[2:0], i[1], 3'b100});
				wupd();
				`CHK("recovery", wrr[i], cfg.write_recovery_count)
				`CHK("pre post", {i[1:0], 1'b1}, {cfg.read_preamble_toggle,
					cfg.read_postamble_len, cfg.write_preamble_two})
			end
		end
		// inactive copy rewritten without a config change
		@(posedge clk_link_i) wsel <= 1'b1;
		ctl.mrw(8'h01, 8'h25);
		n = 0;
		repeat (20) @(negedge clk_sys_i) n += int'(upd);
		`CHK("idle copy", 0, n)
		ctl.mrr(8'h01, rd, ok);
		`CHK("copy one", 9'h125, {ok, rd})
		@(posedge clk_link_i) wsel <= 1'b0;
		ctl.mrr(8'h01, rd, ok);
		`CHK("copy zero", 9'h104, {ok, rd})
		@(posedge clk_link_i) osel <= 1'b1;
		wupd();
		`CHK("active burst", 2'h1, cfg.burst_length)
		`CHK("active rec", 6'h10, cfg.write_recovery_count)
		// bursts from copy one: read latency 16, write latency 8
		@(posedge clk_link_i) wsel <= 1'b1;
		ctl.mrw(8'h02, 8'h4a);
		wupd();
		ctl.mrw(8'h01, 8'h34);
		wupd();
		run(1'b0, 1'b0, 1'b1, 8'h01, 16, 16, 8);
		ctl.mrw(8'h01, 8'h35);
		wupd();
		run(1'b1, 1'b0, 1'b1, 8'h13, 8, 32, 20);
		ctl.mrw(8'h01, 8'h36);
		wupd();
		run(1'b0, 1'b1, 1'b1, 8'h03, 16, 32, 16);
		run(1'b0, 1'b0, 1'b0, 8'h03, 16, 16, 0);
		// leveling blocks reads, commands and feature-one writes
		ctl.mrw(8'h02, 8'hca);
		wupd();
		`CHK("lev cfg", 1'b1, cfg.write_leveling)
		repeat (2) @(negedge clk_link_i);
		`CHK("leveling", 2'h2, {lev, ready})
		ctl.mrr(8'h01, rd, ok);
		`CHK("refused read", 1'b0, ok)
		ctl.mrw(8'h01, 8'h04);
		ctl.mrw(8'h02, 8'h4a);
		repeat (2) @(negedge clk_link_i);
		ctl.mrr(8'h01, rd, ok);
		`CHK("kept", 9'h136, {ok, rd})
		complete_run();
	end
endmodule

`default_nettype wire
